// file: rtl/tpc_regs.vh
// register offsets, field positions, reset values, mode and shape codes and the system clock rate for the pwm control block
`ifndef TPC_REGS_VH
`define TPC_REGS_VH
`define TPC_ADDR_CTRL        8'h00
`define TPC_ADDR_PERIOD      8'h04
`define TPC_ADDR_DUTY_A      8'h08
`define TPC_ADDR_DUTY_B      8'h0C
`define TPC_ADDR_DUTY_C      8'h10
`define TPC_ADDR_DEAD        8'h14
`define TPC_ADDR_SWEN        8'h18
`define TPC_ADDR_STATUS      8'h1C
`define TPC_ADDR_MASK        8'h20
`define TPC_ADDR_FAULT       8'h24
`define TPC_CTRL_MODE_LSB    0
`define TPC_CTRL_SHAPE_LSB   2
`define TPC_CTRL_ENABLE_BIT  4
`define TPC_CTRL_RESET       32'h00000000
`define TPC_PERIOD_RESET     32'h000003E8
`define TPC_DEAD_RESET       32'h00000004
`define TPC_SWEN_RESET       32'h0000003F
`define TPC_MODE_SIX0        2'h0
`define TPC_MODE_SIX1        2'h1
`define TPC_MODE_THREE       2'h2
`define TPC_MODE_GEN         2'h3
`define TPC_SHAPE_UPDOWN     2'h0
`define TPC_SHAPE_UP         2'h1
`define TPC_SHAPE_DOWN       2'h2
`define TPC_ST_FAULT_BIT     0
`define TPC_ST_WRAP_BIT      1
`define TPC_SYSCLK_MHZ       250
`endif

// file: rtl/tpc_pwm_ctrl.v
// three-phase pwm control-mode logic with axi4-lite register slave
`timescale 1ns/1ns
`include "tpc_regs.vh"
module tpc_pwm_ctrl #(
    parameter CW        = 16,
    parameter DW        = 8,
    parameter STRAP_VAR = 0
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        sleep_n_input,
    input  wire        mode_strap_tied_low,
    input  wire [2:0]  phase_high_input,
    input  wire [2:0]  phase_low_input,
    input  wire [2:0]  fault_events,
    output reg  [2:0]  phase_output,
    output reg  [2:0]  phase_output_en,
    output reg  [2:0]  high_gate_on,
    output reg  [2:0]  low_gate_on,
    output reg         fault_n_output,
    output wire        irq
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg  [4:0]    generator_control_reg;
reg  [CW-1:0] generator_period_reg;
reg  [CW-1:0] phase_duty_reg [0:2];
reg  [DW-1:0] dead_time_reg;
reg  [5:0]    switch_enable;
reg  [1:0]    intStatus;
reg  [1:0]    intMask;
reg  [2:0]    faultDetail;
reg           strapMode3;
reg           strapTaken;
reg           sleepPrev;
// full-width reset words, cut to each register's width
wire [31:0]   ctrlReset   = `TPC_CTRL_RESET;
wire [31:0]   periodReset = `TPC_PERIOD_RESET;
wire [31:0]   deadReset   = `TPC_DEAD_RESET;
wire [31:0]   swenReset   = `TPC_SWEN_RESET;

wire [1:0] modeField  = generator_control_reg[`TPC_CTRL_MODE_LSB+1:`TPC_CTRL_MODE_LSB];
wire [1:0] counter_shape_select =
    generator_control_reg[`TPC_CTRL_SHAPE_LSB+1:`TPC_CTRL_SHAPE_LSB];
wire       genEnable  = generator_control_reg[`TPC_CTRL_ENABLE_BIT];
// strap variant uses latched strap, never generation
wire [1:0] activeMode = (STRAP_VAR != 0) ? (strapMode3 ? `TPC_MODE_THREE : `TPC_MODE_SIX0)
                                         : modeField;

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave: address and data taken together, one answer at a time
wire wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
wire rdGo = s_axi_arvalid && !s_axi_rvalid;
assign s_axi_awready = wrGo;
assign s_axi_wready  = wrGo;
assign s_axi_arready = rdGo;
wire wrHit = (s_axi_awaddr <= `TPC_ADDR_FAULT) && (s_axi_awaddr[1:0] == 2'h0);
wire rdHit = (s_axi_araddr <= `TPC_ADDR_FAULT) && (s_axi_araddr[1:0] == 2'h0);
wire rdStatus = rdGo && (s_axi_araddr == `TPC_ADDR_STATUS);

reg [31:0] rdMux;
always @*
begin
    case (s_axi_araddr)
        `TPC_ADDR_CTRL:   rdMux = {27'h0, generator_control_reg};
        `TPC_ADDR_PERIOD: rdMux = {{(32-CW){1'b0}}, generator_period_reg};
        `TPC_ADDR_DUTY_A: rdMux = {{(32-CW){1'b0}}, phase_duty_reg[0]};
        `TPC_ADDR_DUTY_B: rdMux = {{(32-CW){1'b0}}, phase_duty_reg[1]};
        `TPC_ADDR_DUTY_C: rdMux = {{(32-CW){1'b0}}, phase_duty_reg[2]};
        `TPC_ADDR_DEAD:   rdMux = {{(32-DW){1'b0}}, dead_time_reg};
        `TPC_ADDR_SWEN:   rdMux = {26'h0, switch_enable};
        `TPC_ADDR_STATUS: rdMux = {30'h0, intStatus};
        `TPC_ADDR_MASK:   rdMux = {30'h0, intMask};
        `TPC_ADDR_FAULT:  rdMux = {29'h0, faultDetail};
        default:          rdMux = 32'h00000000;
    endcase
end

always @(posedge clk)
begin
    if (rst)
    begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= 2'h0;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp  <= 2'h0;
        s_axi_rdata  <= 32'h00000000;
    end
    else
    begin
        if (wrGo)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? 2'h0 : 2'h2;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (rdGo)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rdHit ? 2'h0 : 2'h2;
            s_axi_rdata  <= rdMux;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register writes (low byte lanes honoured)
wire [31:0] wMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                     {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
wire wrOk = wrGo && wrHit;
integer i;
always @(posedge clk)
begin
    if (rst)
    begin
        generator_control_reg <= ctrlReset[4:0];
        generator_period_reg  <= periodReset[CW-1:0];
        dead_time_reg         <= deadReset[DW-1:0];
        switch_enable         <= swenReset[5:0];
        intMask               <= 2'h0;
        for (i = 0; i < 3; i = i + 1)
            phase_duty_reg[i] <= {CW{1'b0}};
    end
    else if (wrOk)
    begin
        case (s_axi_awaddr)
            `TPC_ADDR_CTRL:   generator_control_reg <= (s_axi_wdata[4:0] & wMask[4:0])
                                  | (generator_control_reg & ~wMask[4:0]);
            `TPC_ADDR_PERIOD: generator_period_reg <= (s_axi_wdata[CW-1:0] & wMask[CW-1:0])
                                  | (generator_period_reg & ~wMask[CW-1:0]);
            `TPC_ADDR_DUTY_A: phase_duty_reg[0] <= (s_axi_wdata[CW-1:0] & wMask[CW-1:0])
                                  | (phase_duty_reg[0] & ~wMask[CW-1:0]);
            `TPC_ADDR_DUTY_B: phase_duty_reg[1] <= (s_axi_wdata[CW-1:0] & wMask[CW-1:0])
                                  | (phase_duty_reg[1] & ~wMask[CW-1:0]);
            `TPC_ADDR_DUTY_C: phase_duty_reg[2] <= (s_axi_wdata[CW-1:0] & wMask[CW-1:0])
                                  | (phase_duty_reg[2] & ~wMask[CW-1:0]);
            `TPC_ADDR_DEAD:   dead_time_reg <= (s_axi_wdata[DW-1:0] & wMask[DW-1:0])
                                  | (dead_time_reg & ~wMask[DW-1:0]);
            `TPC_ADDR_SWEN:   switch_enable <= (s_axi_wdata[5:0] & wMask[5:0])
                                  | (switch_enable & ~wMask[5:0]);
            `TPC_ADDR_MASK:   intMask <= (s_axi_wdata[1:0] & wMask[1:0])
                                  | (intMask & ~wMask[1:0]);
            default:          intMask <= intMask;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// mode strap capture after reset release and on each wake
always @(posedge clk)
begin
    if (rst)
    begin
        strapTaken <= 1'b0;
        strapMode3 <= 1'b0;
        sleepPrev  <= 1'b0;
    end
    else
    begin
        sleepPrev <= sleep_n_input;
        if (!strapTaken || (sleep_n_input && !sleepPrev))
        begin
            strapTaken <= 1'b1;
            strapMode3 <= !mode_strap_tied_low;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// reference counter
reg  [CW-1:0] refCount;
reg           countUp;
reg           syncPrev;
reg           wrapPulse;
wire          syncRise = phase_low_input[1] && !syncPrev;
wire          genMode  = (activeMode == `TPC_MODE_GEN);

always @(posedge clk)
begin
    if (rst)
    begin
        refCount  <= {CW{1'b0}};
        countUp   <= 1'b0;
        syncPrev  <= 1'b0;
        wrapPulse <= 1'b0;
    end
    else
    begin
        syncPrev  <= phase_low_input[1];
        wrapPulse <= 1'b0;
        if (!genMode || !genEnable)
        begin
            refCount <= (counter_shape_select == `TPC_SHAPE_UP) ? {CW{1'b0}}
                                                                : generator_period_reg;
            countUp  <= 1'b0;
        end
        else
        begin
            case (counter_shape_select)
                `TPC_SHAPE_UPDOWN:
                begin
                    if (countUp)
                    begin
                        if (refCount >= generator_period_reg)
                        begin
                            countUp   <= 1'b0;
                            refCount  <= refCount - 1'b1;
                            wrapPulse <= 1'b1;
                        end
                        else
                            refCount <= refCount + 1'b1;
                    end
                    else if (refCount == {CW{1'b0}})
                    begin
                        countUp  <= 1'b1;
                        refCount <= refCount + 1'b1;
                    end
                    else
                        refCount <= refCount - 1'b1;
                end
                `TPC_SHAPE_UP:
                begin
                    if (refCount >= generator_period_reg)
                    begin
                        refCount  <= {CW{1'b0}};
                        wrapPulse <= 1'b1;
                    end
                    else
                        refCount <= refCount + 1'b1;
                end
                `TPC_SHAPE_DOWN:
                begin
                    if (refCount == {CW{1'b0}})
                    begin
                        refCount  <= generator_period_reg;
                        wrapPulse <= 1'b1;
                    end
                    else
                        refCount <= refCount - 1'b1;
                end
                default:
                    refCount <= refCount;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// per-phase compare, dead time and output decode
genvar p;
generate
    for (p = 0; p < 3; p = p + 1)
    begin : gPhase
        reg  [DW-1:0] deadCount;
        reg           pwmHigh;
        reg           pwmPrev;
        // duty above period makes compare always true
        wire rawHigh = genEnable && (phase_duty_reg[p] > refCount);
        always @(posedge clk)
        begin
            if (rst)
            begin
                pwmHigh   <= 1'b0;
                pwmPrev   <= 1'b0;
                deadCount <= {DW{1'b0}};
            end
            else
            begin
                pwmHigh <= rawHigh;
                pwmPrev <= pwmHigh;
                if (pwmHigh != pwmPrev)
                    deadCount <= dead_time_reg;
                else if (deadCount != {DW{1'b0}})
                    deadCount <= deadCount - 1'b1;
            end
        end
        wire deadDone = (deadCount == {DW{1'b0}}) && (pwmHigh == pwmPrev);
        always @(posedge clk)
        begin
            if (rst)
            begin
                high_gate_on[p]    <= 1'b0;
                low_gate_on[p]     <= 1'b0;
                phase_output[p]    <= 1'b0;
                phase_output_en[p] <= 1'b0;
            end
            else
            begin
                case (activeMode)
                    `TPC_MODE_SIX0, `TPC_MODE_SIX1:
                    begin
                        high_gate_on[p] <= phase_high_input[p] && !phase_low_input[p];
                        low_gate_on[p]  <= phase_low_input[p] && !phase_high_input[p];
                    end
                    `TPC_MODE_THREE:
                    begin
                        high_gate_on[p] <= phase_low_input[p] && phase_high_input[p];
                        low_gate_on[p]  <= phase_low_input[p] && !phase_high_input[p];
                    end
                    default:
                    begin
                        high_gate_on[p] <= switch_enable[p] && pwmHigh && deadDone;
                        low_gate_on[p]  <= switch_enable[p+3] && genEnable
                                           && !pwmHigh && deadDone;
                    end
                endcase
                phase_output[p]    <= high_gate_on[p];
                phase_output_en[p] <= high_gate_on[p] || low_gate_on[p];
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// fault record and interrupt status
wire [1:0] evSet = {wrapPulse, |fault_events};
always @(posedge clk)
begin
    if (rst)
    begin
        intStatus      <= 2'h0;
        faultDetail    <= 3'h0;
        fault_n_output <= 1'b1;
    end
    else
    begin
        // set wins over read clear
        intStatus      <= (rdStatus ? 2'h0 : intStatus) | evSet;
        faultDetail    <= ((rdGo && s_axi_araddr == `TPC_ADDR_FAULT) ? 3'h0 : faultDetail)
                          | fault_events;
        fault_n_output <= !(|fault_events);
    end
end
assign irq = |(intStatus & intMask);

endmodule // tpc_pwm_ctrl

// file: bench/tpc_host_model.sv
// host model driving the phase inputs of the pwm control block
`timescale 1ns/1ns
module tpc_host_model (
    input  wire        clk,
    input  wire        quiet,
    input  wire        scramble,
    input  wire  [2:0] hiReq,
    input  wire  [2:0] loReq,
    output logic [2:0] hiIn = 3'h0,
    output logic [2:0] loIn = 3'h0
);
    always @(posedge clk)
    begin
        if (quiet)
            {hiIn, loIn} <= 6'h00;
        else if (scramble)
            {hiIn, loIn} <= {hiIn, loIn} + 6'h25;
        else
            {hiIn, loIn} <= {hiReq, loReq};
    end
endmodule // tpc_host_model

// file: bench/tpc_pwm_ctrl_sva.sv
// assertions on the port behaviour of the pwm control block
`timescale 1ns/1ns
module tpc_pwm_ctrl_sva (
    input wire        clk,
    input wire        rst,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [2:0]  fault_events,
    input wire        fault_n_output,
    input wire [2:0]  high_gate_on,
    input wire [2:0]  low_gate_on,
    input wire [2:0]  phase_output,
    input wire [2:0]  phase_output_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_fault_pin_low: assert property ((|fault_events) |=> !fault_n_output)
        else $error("fault output not low after event");
    chk_gate_no_overlap: assert property ((high_gate_on & low_gate_on) == 3'h0)
        else $error("both gates on in one phase");
    chk_hiz_no_gate: assert property (phase_output_en == $past(high_gate_on | low_gate_on))
        else $error("output enable does not follow gates");
    chk_level_high_gate: assert property ((phase_output & phase_output_en) ==
        ($past(high_gate_on) & phase_output_en))
        else $error("output level does not follow high gate");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> s_axi_bvalid)
        else $error("no write response");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_reset_quiet: assert property ($past(rst) |-> fault_n_output && high_gate_on == 3'h0
        && low_gate_on == 3'h0)
        else $error("outputs not quiet after reset");
endmodule // tpc_pwm_ctrl_sva
bind tpc_pwm_ctrl tpc_pwm_ctrl_sva chk_u (.clk(clk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fault_events(fault_events),
    .fault_n_output(fault_n_output), .high_gate_on(high_gate_on), .low_gate_on(low_gate_on),
    .phase_output(phase_output), .phase_output_en(phase_output_en));

// file: bench/test_tpc_pwm_ctrl.sv
// self-checking bench for the three-phase pwm control block
`timescale 1ns/1ns
`include "tpc_regs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_tpc_pwm_ctrl;
    localparam PRD = 20, DEADV = 2, M = 420;
    logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, quiet = 1'b1, scramble = 1'b0, sampleReq = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [2:0]  hiReq = 3'h0, loReq = 3'h0, faultEv = 3'h0, h, l;
    logic [3:0]  wstrb = 4'hF;
    logic        sleepN = 1'b1, strapLow = 1'b1;
    logic [5:0]  e6;
    logic [33:0] obsVal = 34'h0, expv, q[$];
    wire         awready, wready, bvalid, arready, rvalid, faultN, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [2:0]  hiIn, loIn, phOut, phEn, hiG, loG, phOut2, phEn2;
    integer      seed = 85091, mismatches = 0, checks = 0, cycles = 0, edA, s, m, d, prevA;
    integer      hiC[3], loC[3];
    always #2 clk = ~clk;
    tpc_host_model host_u (.clk(clk), .quiet(quiet), .scramble(scramble), .hiReq(hiReq),
        .loReq(loReq), .hiIn(hiIn), .loIn(loIn));
    tpc_pwm_ctrl #(.CW(16), .DW(8), .STRAP_VAR(0)) dut_u (.clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_n_input(sleepN), .mode_strap_tied_low(strapLow),
        .phase_high_input(hiIn), .phase_low_input(loIn), .fault_events(faultEv),
        .phase_output(phOut), .phase_output_en(phEn), .high_gate_on(hiG), .low_gate_on(loG),
        .fault_n_output(faultN), .irq(irq));
    // strap variant: mode comes from the latched strap only
    tpc_pwm_ctrl #(.STRAP_VAR(1)) strap_u (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
        .s_axi_rready(rready), .sleep_n_input(sleepN), .mode_strap_tied_low(strapLow),
        .phase_high_input(hiIn), .phase_low_input(loIn), .fault_events(faultEv),
        .phase_output(phOut2), .phase_output_en(phEn2), .high_gate_on(), .low_gate_on(),
        .fault_n_output(), .irq());
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        if (bvalid && bready) begin expv = q.pop_front(); `CHK({32'h0, bresp}, expv) end
        if (rvalid && rready) begin expv = q.pop_front(); `CHK({rresp, rdata}, expv) end
        if (sampleReq) begin expv = q.pop_front(); `CHK(obsVal, expv) end
        cycles++;
        if (cycles == 30000) begin mismatches++; end_of_test; end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic note(input [33:0] e, input [33:0] o);
        q.push_back(e);
        obsVal <= o;
        sampleReq <= 1'b1;
        @(posedge clk);
        sampleReq <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input [7:0] a, input [31:0] dv, input [1:0] r);
        q.push_back({32'h0, r});
        awaddr <= a;
        wdata <= dv;
        {awvalid, wvalid} <= 2'h3;
        bready <= !a[2];
        @(posedge clk);
        while (!(awready && wready)) @(posedge clk);
        {awvalid, wvalid} <= 2'h0;
        @(posedge clk);
        // some responses are left waiting a cycle so the slave must hold them
        while (!(bvalid && bready))
        begin
            bready <= 1'b1;
            @(posedge clk);
        end
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input [7:0] a, input [31:0] dv, input [1:0] r);
        q.push_back({r, dv});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !a[2];
        @(posedge clk);
        while (!arready) @(posedge clk);
        arvalid <= 1'b0;
        @(posedge clk);
        while (!(rvalid && rready))
        begin
            rready <= 1'b1;
            @(posedge clk);
        end
        rready <= 1'b0;
        @(posedge clk);
    endtask
    // phase inputs go low around every control rewrite
    task automatic setMode(input [31:0] v);
        quiet <= 1'b1;
        repeat (3) @(posedge clk);
        wr(`TPC_ADDR_CTRL, v, 2'h0);
        quiet <= 1'b0;
    endtask
    task automatic measure;
        repeat (60) @(posedge clk);
        edA = 0;
        prevA = 1;
        hiC = '{0, 0, 0};
        loC = '{0, 0, 0};
        repeat (M)
        begin
            @(posedge clk);
            for (int i = 0; i < 3; i++) begin hiC[i] += hiG[i]; loC[i] += loG[i]; end
            edA += (hiG[0] && !prevA);
            prevA = hiG[0];
        end
    endtask
    task end_of_test;
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`TPC_ADDR_CTRL, `TPC_CTRL_RESET, 2'h0);
        rd(`TPC_ADDR_PERIOD, `TPC_PERIOD_RESET, 2'h0);
        rd(`TPC_ADDR_DEAD, `TPC_DEAD_RESET, 2'h0);
        rd(`TPC_ADDR_SWEN, `TPC_SWEN_RESET, 2'h0);
        rd(8'h28, 32'h0, 2'h2);
        wr(8'h28, 32'h5, 2'h2);
        for (m = 0; m < 3; m++)
        begin
            setMode(m);
            if (m == 2)
            begin
                // strap moves to floating only while asleep, then wake re-latches it
                sleepN <= 1'b0;
                @(posedge clk);
                strapLow <= 1'b0;
                @(posedge clk);
                sleepN <= 1'b1;
            end
            repeat (6)
            begin
                h = $random(seed);
                l = $random(seed);
                hiReq <= h;
                loReq <= l;
                repeat (5) @(posedge clk);
                e6 = (m == 2) ? {l, h & l} : {h ^ l, h & ~l};
                note(e6, {phEn, phOut & phEn});
                note(e6, {phEn2, phOut2 & phEn2});
            end
        end
        scramble <= 1'b1;
        setMode(`TPC_MODE_GEN);
        wr(`TPC_ADDR_PERIOD, PRD, 2'h0);
        wr(`TPC_ADDR_DUTY_A, 32'hA, 2'h0);
        wr(`TPC_ADDR_DUTY_B, 32'h0, 2'h0);
        wr(`TPC_ADDR_DUTY_C, PRD + 10, 2'h0);
        wr(`TPC_ADDR_DEAD, DEADV, 2'h0);
        repeat (10) @(posedge clk);
        note(0, hiG);
        for (s = 0; s < 3; s++)
        begin
            setMode(3 | s << 2 | 16);
            measure;
            note(1, (s == 0) ? (edA >= 9 && edA <= 12) : (edA >= 18 && edA <= 22));
            note(0, hiC[1]);
            note(M, loC[1]);
            note(M, hiC[2]);
            d = M - 2 * (DEADV + 1) * edA - hiC[0] - loC[0];
            note(1, d >= -8 && d <= 8);
        end
        wr(`TPC_ADDR_SWEN, 32'h2B, 2'h0);
        measure;
        note(0, hiC[2]);
        note(0, loC[1]);
        setMode(`TPC_MODE_GEN);
        rd(`TPC_ADDR_STATUS, 32'h2, 2'h0);
        rd(`TPC_ADDR_STATUS, 32'h0, 2'h0);
        faultEv <= 3'h2;
        @(posedge clk);
        faultEv <= 3'h0;
        @(posedge clk);
        note(0, faultN);
        wr(`TPC_ADDR_MASK, 32'h1, 2'h0);
        note(1, irq);
        rd(`TPC_ADDR_STATUS, 32'h1, 2'h0);
        note(0, irq);
        rd(`TPC_ADDR_FAULT, 32'h2, 2'h0);
        rd(`TPC_ADDR_FAULT, 32'h0, 2'h0);
        // only byte lane 1 may land
        wstrb <= 4'h2;
        wr(`TPC_ADDR_DUTY_B, 32'hFFFF, 2'h0);
        wstrb <= 4'hF;
        rd(`TPC_ADDR_DUTY_B, 32'hFF00, 2'h0);
        end_of_test;
    end
endmodule // test_tpc_pwm_ctrl
